// ### core/psm_cfg_device.sv
// device end: mode word, output-function selectors and rail output logic
`timescale 1ns/100ps
`default_nettype none
module psm_cfg_device
  import psm_cfg_pkg::*;
#(
  parameter int SEQ_WINDOW = SEQ_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // link to the bus host
  pmbus_link_if.dev link,
  // chip-side inputs
  input wire logic [OUT_NUM-1:0] seq_enable_in,
  input wire logic [CH_NUM-1:0] chan_good_in,
  input wire logic [CH_NUM-1:0] chan_alarm_in,
  input wire logic alert_pending_in,
  input wire logic unlock_in,
  input wire logic [15:0] current_mean_result_in,
  // chip-side outputs
  output logic [OUT_NUM-1:0] rail_enable_or_gp_output_out,
  output logic soft_reset_out,
  output logic locked_out,
  output logic alert_enable_out,
  output logic [8:0] conv_cycles_out,
  output logic [3:0] adc_avg_samples_out,
  output logic [15:0] current_mean_depth_out
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic [15:0] mode_r;
  logic [15:0] mode_nxt;
  logic [31:0] cfg_r [OUT_NUM];
  logic [1:0] fire_r;
  logic locked_r;

  // page selects one of the twelve outputs; pages above are unmapped
  wire hit_mode = (link.code == CODE_MODE);
  wire hit_cfg = (link.code == CODE_OUT_CFG) && (link.page < 4'(OUT_NUM));
  wire hit_mean = (link.code == CODE_MEAN);
  wire hit_any = hit_mode | hit_cfg | hit_mean;
  wire wr_mode = link.req & link.we & hit_mode;
  wire wr_cfg = link.req & link.we & hit_cfg;
  wire [31:0] rd_cfg = hit_cfg ? cfg_r[link.page] : 32'h0000_0000;
  wire [31:0] rd_data = hit_mode ? {16'h0000, mode_r} :
                        hit_cfg ? rd_cfg :
                        hit_mean ? {16'h0000, current_mean_result_in} :
                        32'h0000_0000;

  // ---------------------------------------------------------------
  // mode word
  // ---------------------------------------------------------------
  // a host write wins over an unlock arriving in the same cycle
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = link.wdata[15:0] & MODE_RW_MASK;
    end else if (unlock_in) begin
      mode_nxt[MODE_LOCK_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r <= MODE_RESET;
    end else if (ce_in) begin
      mode_r <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // set-clear-set detectors: 0 soft reset, 1 lock
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < 2; g++) begin : g_seq
      localparam int B = (g == 0) ? MODE_SRST_BIT : MODE_LOCK_BIT;
      seq_state_t st_r;
      logic [TMR_W-1:0] tmr_r;
      wire wbit = link.wdata[B];
      wire expired = (tmr_r == '0);

      // window counts from the first set; late steps drop back to idle
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          st_r <= SEQ_IDLE;
          tmr_r <= '0;
          fire_r[g] <= 1'b0;
        end else if (ce_in) begin
          fire_r[g] <= 1'b0;
          case (st_r)
            SEQ_IDLE: begin
              if (wr_mode && wbit) begin
                st_r <= SEQ_ARMED;
                tmr_r <= TMR_W'(SEQ_WINDOW - 1);
              end
            end
            SEQ_ARMED: begin
              if (expired) begin
                st_r <= SEQ_IDLE;
              end else begin
                tmr_r <= tmr_r - 1'b1;
                if (wr_mode && !wbit) begin
                  st_r <= SEQ_CLEARED;
                end
              end
            end
            SEQ_CLEARED: begin
              if (expired) begin
                st_r <= SEQ_IDLE;
              end else begin
                tmr_r <= tmr_r - 1'b1;
                if (wr_mode && wbit) begin
                  st_r <= SEQ_IDLE;
                  fire_r[g] <= 1'b1;
                end
              end
            end
            default: begin
              st_r <= SEQ_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // lock state; a lock completing with an unlock in the same cycle stays locked
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      locked_r <= 1'b0;
    end else if (ce_in) begin
      if (fire_r[1]) begin
        locked_r <= 1'b1;
      end else if (unlock_in) begin
        locked_r <= 1'b0;
      end
    end
  end

  assign soft_reset_out = fire_r[0];
  assign locked_out = locked_r;
  // ---------------------------------------------------------------
  // output-function selectors and rail outputs
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < OUT_NUM; i++) begin : g_out
      wire [2:0] sel = cfg_r[i][2:0];
      wire [CH_NUM-1:0] mask = cfg_r[i][CFG_MASK_LSB +: CH_NUM];
      wire good_and = &(chan_good_in | ~mask);
      wire alarm_or = |(chan_alarm_in & mask);
      // reserved codes park the pin deasserted rather than guess a function
      wire level = (sel == SEL_RAIL) ? seq_enable_in[i] :
                   (sel == SEL_FORCE_ON) ? 1'b1 :
                   (sel == SEL_FORCE_OFF) ? 1'b0 :
                   (sel == SEL_GOOD_AND) ? good_and :
                   (sel == SEL_ALARM_OR) ? alarm_or :
                   1'b0;

      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          cfg_r[i] <= CFG_RESET;
          rail_enable_or_gp_output_out[i] <= 1'b0;
        end else if (ce_in) begin
          if (wr_cfg && (link.page == 4'(i))) begin
            cfg_r[i] <= link.wdata & CFG_RW_MASK;
          end
          rail_enable_or_gp_output_out[i] <= level;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // converter settings decoded from the mode word
  // ---------------------------------------------------------------
  wire [1:0] ct_code = mode_r[MODE_CT_LSB +: 2];
  wire [1:0] avg_code = mode_r[MODE_AVG_LSB +: 2];
  wire [3:0] depth_code = mode_r[MODE_DEPTH_LSB +: 4];
  wire [8:0] conv_nxt = CONV_BASE_CYC << ct_code;
  wire [3:0] avg_nxt = (avg_code == 2'h3) ? AVG_MAX_SAMPLES :
                       (4'h1 << avg_code);
  wire [15:0] depth_nxt = 16'h0001 << depth_code;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_cycles_out <= CONV_BASE_CYC;
      adc_avg_samples_out <= 4'h1;
      current_mean_depth_out <= 16'h0001;
      alert_enable_out <= 1'b0;
    end else if (ce_in) begin
      conv_cycles_out <= conv_nxt;
      adc_avg_samples_out <= avg_nxt;
      current_mean_depth_out <= depth_nxt;
      alert_enable_out <= mode_r[MODE_ALERT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // link answers
  // ---------------------------------------------------------------
  // every request is answered one cycle later; writes to the mean result
  // are accepted but change nothing
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.rsp_valid <= 1'b0;
      link.rsp_err <= 1'b0;
      link.rdata <= 32'h0000_0000;
      link.ara_ack <= 1'b0;
    end else if (ce_in) begin
      link.rsp_valid <= link.req;
      link.rsp_err <= link.req & ~hit_any;
      link.rdata <= (link.req && !link.we) ? rd_data : 32'h0000_0000;
      link.ara_ack <= link.ara_req & mode_r[MODE_ALERT_BIT] & alert_pending_in;
    end
  end

endmodule : psm_cfg_device
`default_nettype wire

// ### core/psm_cfg_pkg.sv
// shared constants and types for the mode word and output-function block
package psm_cfg_pkg;

  // ---------------------------------------------------------------
  // command codes on the link
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_MODE = 8'hd1;
  localparam logic [7:0] CODE_OUT_CFG = 8'hd2;
  localparam logic [7:0] CODE_MEAN = 8'he2;
  localparam logic [7:0] CODE_CHAN_CFG = 8'he4;
  localparam logic [31:0] CHAN_SEL_SEQ = 32'h0000_0010;

  // ---------------------------------------------------------------
  // device_mode_word layout
  // ---------------------------------------------------------------
  localparam int MODE_ALERT_BIT = 13;
  localparam int MODE_SRST_BIT = 11;
  localparam int MODE_LOCK_BIT = 10;
  localparam int MODE_CT_LSB = 6;
  localparam int MODE_AVG_LSB = 4;
  localparam int MODE_DEPTH_LSB = 0;
  localparam logic [15:0] MODE_RW_MASK = 16'h2cff;
  localparam logic [15:0] MODE_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // output_function_config layout
  // ---------------------------------------------------------------
  localparam int OUT_NUM = 12;
  localparam int CH_NUM = 16;
  localparam int CFG_MASK_LSB = 16;
  localparam logic [31:0] CFG_RW_MASK = 32'hffff_0007;
  localparam logic [31:0] CFG_RESET = 32'h0000_0002;
  localparam logic [2:0] SEL_RAIL = 3'h0;
  localparam logic [2:0] SEL_FORCE_ON = 3'h1;
  localparam logic [2:0] SEL_FORCE_OFF = 3'h2;
  localparam logic [2:0] SEL_GOOD_AND = 3'h3;
  localparam logic [2:0] SEL_ALARM_OR = 3'h4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam longint SEQ_WINDOW_MS = 8;
  // longest time, rounds down
  localparam int SEQ_WINDOW_CYC = int'((SEQ_WINDOW_MS * CLK_HZ) / 1000);
  localparam int TMR_W = 19;
  localparam int CONV_BASE_NS = 1000;
  localparam logic [8:0] CONV_BASE_CYC = 9'((CONV_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // sample count for the largest averaging code
  localparam logic [3:0] AVG_MAX_SAMPLES = 4'h8;
  localparam logic [8:0] LOCK_LIMIT = 9'h100;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ARMED, SEQ_CLEARED} seq_state_t;
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} host_state_t;

endpackage : psm_cfg_pkg

// ### core/pmbus_link_if.sv
// command link joining the bus host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface pmbus_link_if;
  logic req;
  logic we;
  logic [7:0] code;
  logic [3:0] page;
  logic [31:0] wdata;
  logic rsp_valid;
  logic rsp_err;
  logic [31:0] rdata;
  logic ara_req;
  logic ara_ack;

  modport dev (
    input req, we, code, page, wdata, ara_req,
    output rsp_valid, rsp_err, rdata, ara_ack
  );
  modport host (
    output req, we, code, page, wdata, ara_req,
    input rsp_valid, rsp_err, rdata, ara_ack
  );
endinterface : pmbus_link_if
`default_nettype wire

// ### core/psm_cfg_host.sv
// bus host end: issues register commands and the timed bit sequences
`timescale 1ns/100ps
`default_nettype none
module psm_cfg_host
  import psm_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // link to the device
  pmbus_link_if.host link,
  // user command port
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [3:0] cmd_page_in,
  input wire logic [31:0] cmd_wdata_in,
  input wire logic soft_reset_req_in,
  input wire logic lock_req_in,
  input wire logic supplies_running_in,
  input wire logic ara_query_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic err_out,
  output logic refused_out,
  output logic [31:0] rdata_out,
  output logic ara_answered_out,
  output logic [8:0] lock_count_out
);
  // ---------------------------------------------------------------
  // command acceptance
  // ---------------------------------------------------------------
  host_state_t st_r;
  logic [7:0] op_code_r [3];
  logic [31:0] op_data_r [3];
  logic op_we_r;
  logic [3:0] op_page_r;
  logic [1:0] op_idx_r;
  logic [1:0] op_last_r;
  logic [15:0] shadow_r;
  logic first_err_r;

  wire idle = (st_r == H_IDLE);
  wire is_cfg_wr = cmd_write_in && (cmd_code_in == CODE_OUT_CFG);
  wire refuse_cfg = cmd_valid_in && is_cfg_wr && supplies_running_in;
  wire refuse_lock = lock_req_in && (lock_count_out == LOCK_LIMIT);
  wire take_cmd = idle && cmd_valid_in && !refuse_cfg;
  wire take_srst = idle && !cmd_valid_in && soft_reset_req_in;
  wire take_lock = idle && !cmd_valid_in && !soft_reset_req_in && lock_req_in && !refuse_lock;
  wire rail_cfg = is_cfg_wr && (cmd_wdata_in[2:0] == SEL_RAIL);
  wire [15:0] srst_on = shadow_r | (16'h0001 << MODE_SRST_BIT);
  wire [15:0] srst_off = shadow_r & ~(16'h0001 << MODE_SRST_BIT);
  wire [15:0] lock_on = shadow_r | (16'h0001 << MODE_LOCK_BIT);
  wire [15:0] lock_off = shadow_r & ~(16'h0001 << MODE_LOCK_BIT);
  wire last_op = (op_idx_r == op_last_r);
  assign cmd_ready_out = idle;
  assign link.req = (st_r == H_ISSUE);
  assign link.we = op_we_r;
  assign link.code = op_code_r[op_idx_r];
  assign link.page = op_page_r;
  assign link.wdata = op_data_r[op_idx_r];

  // ---------------------------------------------------------------
  // sequencer: each step is one request and its answer
  // ---------------------------------------------------------------
  // three mode writes go back to back, well inside the window
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= H_IDLE;
      op_code_r <= '{default: 8'h00};
      op_data_r <= '{default: 32'h0000_0000};
      op_we_r <= 1'b0;
      op_page_r <= 4'h0;
      op_idx_r <= 2'h0;
      op_last_r <= 2'h0;
      shadow_r <= MODE_RESET;
      first_err_r <= 1'b0;
      lock_count_out <= 9'h000;
      done_out <= 1'b0;
      err_out <= 1'b0;
      refused_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      done_out <= 1'b0;
      refused_out <= idle && (refuse_cfg || (!cmd_valid_in && !soft_reset_req_in && refuse_lock));
      case (st_r)
        H_IDLE: begin
          op_idx_r <= 2'h0;
          if (take_cmd) begin
            st_r <= H_ISSUE;
            op_we_r <= cmd_write_in;
            op_page_r <= cmd_page_in;
            op_code_r[0] <= cmd_code_in;
            op_data_r[0] <= cmd_wdata_in;
            op_code_r[1] <= CODE_CHAN_CFG;
            op_data_r[1] <= CHAN_SEL_SEQ;
            op_last_r <= (rail_cfg) ? 2'h1 : 2'h0;
            if (cmd_write_in && (cmd_code_in == CODE_MODE)) begin
              shadow_r <= cmd_wdata_in[15:0] & MODE_RW_MASK;
            end
          end else if (take_srst || take_lock) begin
            st_r <= H_ISSUE;
            op_we_r <= 1'b1;
            op_page_r <= 4'h0;
            op_last_r <= 2'h2;
            op_code_r <= '{CODE_MODE, CODE_MODE, CODE_MODE};
            op_data_r[0] <= {16'h0000, take_srst ? srst_on : lock_on};
            op_data_r[1] <= {16'h0000, take_srst ? srst_off : lock_off};
            op_data_r[2] <= {16'h0000, take_srst ? srst_on : lock_on};
            shadow_r <= take_srst ? srst_on : lock_on;
            if (take_lock) begin
              lock_count_out <= lock_count_out + 9'h001;
            end
          end
        end
        H_ISSUE: begin
          st_r <= H_WAIT;
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            if (op_idx_r == 2'h0) begin
              first_err_r <= link.rsp_err;
              rdata_out <= link.rdata;
            end
            if (last_op) begin
              st_r <= H_IDLE;
              done_out <= 1'b1;
              // the channel-select write is a courtesy; its answer is not reported
              err_out <= (op_idx_r == 2'h0) ? link.rsp_err : first_err_r;
            end else begin
              st_r <= H_ISSUE;
              op_idx_r <= op_idx_r + 2'h1;
            end
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // alert response query
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.ara_req <= 1'b0;
      ara_answered_out <= 1'b0;
    end else if (ce_in) begin
      link.ara_req <= ara_query_in;
      ara_answered_out <= link.ara_ack;
    end
  end
endmodule : psm_cfg_host
`default_nettype wire

// ### sim/psm_cfg_monitor.sv
// concurrent checks on the command link between the host and device ends
`timescale 1ns/100ps
`default_nettype none
module psm_cfg_monitor
  import psm_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] code,
  input wire logic [3:0] page,
  input wire logic [31:0] wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [31:0] rdata,
  input wire logic ara_req,
  input wire logic ara_ack
);
  // ---------------------------------------------------------------
  // helper state and sequences
  // ---------------------------------------------------------------
  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic alert_r;
  wire known_code = code == CODE_MODE || code == CODE_OUT_CFG || code == CODE_MEAN;
  wire rd_mode = req && !we && code == CODE_MODE;
  wire rd_cfg = req && !we && code == CODE_OUT_CFG && page < 4'hc;
  // alert bit tracked from link writes; unlock never touches it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) alert_r <= 1'b0;
    else if (req && we && code == CODE_MODE) alert_r <= wdata[MODE_ALERT_BIT];
  end
  sequence link_take; req; endsequence
  sequence link_answer; ##1 rsp_valid; endsequence
  sequence rail_cfg_wr;
    req && we && code == CODE_OUT_CFG && page < 4'hc && wdata[2:0] == SEL_RAIL;
  endsequence
  sequence chan_seq_wr;
    ##2 req && we && code == CODE_CHAN_CFG && wdata == CHAN_SEL_SEQ && page == $past(page, 2);
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_rsp_timing: assert property (link_take |-> link_answer)
    else $error("link answer missing");
  chk_rsp_pulse: assert property (!req |=> !rsp_valid)
    else $error("link answer without request");
  chk_unmapped_err: assert property (req && !known_code |=> rsp_valid && rsp_err)
    else $error("unmapped code not refused");
  chk_page_range: assert property (req && code == CODE_OUT_CFG && page >= 4'hc |=> rsp_err)
    else $error("output index out of range not refused");
  chk_mode_unused: assert property (rd_mode |=> rdata[31:14] == 0 && !rdata[12] && rdata[9:8] == 0)
    else $error("unused mode bits read nonzero");
  chk_cfg_zero: assert property (rd_cfg |=> rdata[15:3] == 0 && !rsp_err)
    else $error("output config reserved bits nonzero");
  chk_mean_ro: assert property (req && code == CODE_MEAN |=> !rsp_err)
    else $error("mean result access answered error");
  chk_alert_gate: assert property (ara_req && !alert_r |=> !ara_ack)
    else $error("alert query answered while disabled");
  chk_ack_cause: assert property (ara_ack |-> $past(ara_req))
    else $error("alert answer without query");
  chk_write_zero: assert property (req && we |=> rdata == 32'h0)
    else $error("write answer carries data");
  chk_rail_chan: assert property (rail_cfg_wr |-> chan_seq_wr)
    else $error("rail output without channel sequencing setup");
endmodule : psm_cfg_monitor
`default_nettype wire

// ### sim/mode_and_output_select_config_bench.sv
// self-checking bench joining the host end and the device end
`timescale 1ns/100ps
`default_nettype none
module mode_and_output_select_config_bench
  import psm_cfg_pkg::*;
;
  // ---------------------------------------------------------------
  // stimulus, observation and instances
  // ---------------------------------------------------------------
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic cmd_write_in = 1'b0;
  logic [7:0] cmd_code_in = 8'h00;
  logic [3:0] cmd_page_in = 4'h0;
  logic [31:0] cmd_wdata_in = 32'h0;
  logic soft_reset_req_in = 1'b0;
  logic lock_req_in = 1'b0;
  logic supplies_running_in = 1'b0;
  logic ara_query_in = 1'b0;
  logic alert_pending_in = 1'b0;
  logic unlock_in = 1'b0;
  logic [OUT_NUM-1:0] seq_enable_in = '0;
  logic [CH_NUM-1:0] chan_good_in = '0;
  logic [CH_NUM-1:0] chan_alarm_in = '0;
  logic [15:0] current_mean_result_in = 16'hbeef;
  logic cmd_ready_out, done_out, err_out, refused_out, ara_answered_out;
  logic soft_reset_out, locked_out, alert_enable_out;
  logic [31:0] rdata_out;
  logic [8:0] lock_count_out, conv_cycles_out;
  logic [3:0] adc_avg_samples_out;
  logic [15:0] current_mean_depth_out;
  logic [OUT_NUM-1:0] rail_enable_or_gp_output_out;
  int mismatches = 0;
  int cmp_count = 0;
  int srst_cnt = 0;
  logic [31:0] rd;
  logic er, rf;
  logic ce_in = 1'b1;
  // a short window keeps the expiry case cheap to reach
  pmbus_link_if link_if ();
  psm_cfg_device #(.SEQ_WINDOW(50)) psm_cfg_device_inst (.clk_in, .arst_n_in, .ce_in,
    .link(link_if), .seq_enable_in, .chan_good_in, .chan_alarm_in, .alert_pending_in,
    .unlock_in, .current_mean_result_in, .rail_enable_or_gp_output_out, .soft_reset_out,
    .locked_out, .alert_enable_out, .conv_cycles_out, .adc_avg_samples_out,
    .current_mean_depth_out);
  psm_cfg_host psm_cfg_host_inst (.clk_in, .arst_n_in, .ce_in, .link(link_if),
    .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_page_in, .cmd_wdata_in,
    .soft_reset_req_in, .lock_req_in, .supplies_running_in, .ara_query_in, .cmd_ready_out,
    .done_out, .err_out, .refused_out, .rdata_out, .ara_answered_out, .lock_count_out);
  psm_cfg_monitor psm_cfg_monitor_inst (.clk_in, .arst_n_in, .req(link_if.req),
    .we(link_if.we), .code(link_if.code), .page(link_if.page), .wdata(link_if.wdata),
    .rsp_valid(link_if.rsp_valid), .rsp_err(link_if.rsp_err), .rdata(link_if.rdata),
    .ara_req(link_if.ara_req), .ara_ack(link_if.ara_ack));
  // clock and soft reset pulse count
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) if (soft_reset_out === 1'b1) srst_cnt++;
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // bounded wait; a refused request never sees done
  task automatic wait_done;
    int n = 0;
    #1;
    rf = refused_out;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 20);
    if (rf !== 1'b1) check("done", done_out, 1'b1);
    rd = rdata_out;
    er = err_out;
  endtask : wait_done
  task automatic cmd(input logic w, input logic [7:0] c, input logic [3:0] p,
      input logic [31:0] d);
    @(posedge clk_in);
    cmd_valid_in <= 1'b1;
    cmd_write_in <= w;
    cmd_code_in <= c;
    cmd_page_in <= p;
    cmd_wdata_in <= d;
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    wait_done();
  endtask : cmd
  task automatic req_seq(input logic lk);
    @(posedge clk_in);
    if (lk) lock_req_in <= 1'b1;
    else soft_reset_req_in <= 1'b1;
    @(posedge clk_in);
    lock_req_in <= 1'b0;
    soft_reset_req_in <= 1'b0;
    wait_done();
  endtask : req_seq
  task automatic unlock;
    @(posedge clk_in);
    unlock_in <= 1'b1;
    @(posedge clk_in);
    unlock_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : unlock
  function automatic logic exp_out(input int k);
    case (k % 8)
      0: return seq_enable_in[k];
      1: return 1'b1;
      3: return &chan_good_in[1:0];
      4: return |chan_alarm_in[1:0];
      default: return 1'b0;
    endcase
  endfunction : exp_out
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    check("conv reset", conv_cycles_out, 32'h28);
    check("avg reset", adc_avg_samples_out, 32'h1);
    check("depth reset", current_mean_depth_out, 32'h1);
    check("rails reset", rail_enable_or_gp_output_out, 32'h0);
    cmd(1'b0, CODE_MODE, 4'h0, 32'h0);
    check("mode reset", rd, 32'h0);
    cmd(1'b0, CODE_OUT_CFG, 4'h7, 32'h0);
    check("cfg reset", rd, 32'h2);
  endtask : t_reset
  // every field code, with every unused bit written high
  task automatic t_modes;
    logic [15:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {8'hf3, i[1:0], i[3:2], i[3:0]};
      cmd(1'b1, CODE_MODE, 4'h0, {16'h0, v});
      cmd(1'b0, CODE_MODE, 4'h0, 32'h0);
      check("mode word", rd, {16'h0, 8'h20, v[7:0]});
      check("conv time", conv_cycles_out, 32'h28 << i[1:0]);
      check("averaging", adc_avg_samples_out, 32'h1 << i[3:2]);
      check("depth", current_mean_depth_out, 32'h1 << i[3:0]);
    end
  endtask : t_modes
  task automatic t_alert;
    int hits;
    for (int a = 0; a < 2; a++) begin
      cmd(1'b1, CODE_MODE, 4'h0, a ? 32'h2000 : 32'h0);
      hits = 0;
      @(posedge clk_in);
      alert_pending_in <= 1'b1;
      ara_query_in <= 1'b1;
      repeat (6) begin
        @(posedge clk_in);
        #1;
        if (ara_answered_out === 1'b1) hits++;
      end
      ara_query_in <= 1'b0;
      check("alert answer", hits != 0, a);
      check("alert enable", alert_enable_out, a);
    end
  endtask : t_alert
  task automatic t_outputs;
    logic [OUT_NUM-1:0] e;
    for (int k = 0; k < OUT_NUM; k++) cmd(1'b1, CODE_OUT_CFG, 4'(k), {16'h3, 13'h1fff, 3'(k)});
    for (int k = 0; k < OUT_NUM; k++) begin
      cmd(1'b0, CODE_OUT_CFG, 4'(k), 32'h0);
      check("out cfg", rd, {16'h3, 13'h0, 3'(k)});
    end
    // unmasked channels are driven opposite to the result of the masked ones
    for (int p = 0; p < 3; p++) begin
      @(posedge clk_in);
      seq_enable_in <= p[0] ? 12'ha5a : 12'h5a5;
      chan_good_in <= (p == 1) ? 16'h0003 : 16'hfffd;
      chan_alarm_in <= (p == 2) ? 16'h0002 : 16'hfffc;
      repeat (3) @(posedge clk_in);
      #1;
      for (int k = 0; k < OUT_NUM; k++) e[k] = exp_out(k);
      check("rail outputs", rail_enable_or_gp_output_out, e);
    end
  endtask : t_outputs
  task automatic t_misc;
    @(posedge clk_in);
    supplies_running_in <= 1'b1;
    cmd(1'b1, CODE_OUT_CFG, 4'h1, 32'h2);
    check("refused write", rf, 1'b1);
    check("ready kept", cmd_ready_out, 1'b1);
    supplies_running_in <= 1'b0;
    cmd(1'b0, CODE_OUT_CFG, 4'h1, 32'h0);
    check("cfg kept", rd, 32'h0003_0001);
    cmd(1'b0, 8'h55, 4'h0, 32'h0);
    check("unmapped err", er, 1'b1);
    cmd(1'b0, CODE_OUT_CFG, 4'hc, 32'h0);
    check("page err", er, 1'b1);
    cmd(1'b1, CODE_MEAN, 4'h0, 32'h1234);
    check("mean write err", er, 1'b0);
    cmd(1'b0, CODE_MEAN, 4'h0, 32'h0);
    check("mean read", rd, 32'hbeef);
  endtask : t_misc
  task automatic t_soft;
    int s0 = srst_cnt;
    cmd(1'b1, CODE_MODE, 4'h0, 32'h0800);
    repeat (60) @(posedge clk_in);
    cmd(1'b1, CODE_MODE, 4'h0, 32'h0);
    cmd(1'b1, CODE_MODE, 4'h0, 32'h0800);
    repeat (60) @(posedge clk_in);
    check("late soft reset", srst_cnt - s0, 0);
    cmd(1'b1, CODE_MODE, 4'h0, 32'h0);
    req_seq(1'b0);
    repeat (2) @(posedge clk_in);
    check("soft reset", srst_cnt - s0, 1);
    cmd(1'b1, CODE_MODE, 4'h0, 32'h0);
  endtask : t_soft
  task automatic t_lock;
    req_seq(1'b1);
    check("locked", locked_out, 1'b1);
    cmd(1'b0, CODE_MODE, 4'h0, 32'h0);
    check("lock bit", rd[10], 1'b1);
    ce_in <= 1'b0;
    unlock();
    check("frozen lock", locked_out, 1'b1);
    ce_in <= 1'b1;
    unlock();
    check("unlocked", locked_out, 1'b0);
    cmd(1'b0, CODE_MODE, 4'h0, 32'h0);
    check("lock bit clear", rd[10], 1'b0);
    for (int j = 1; j < 256; j++) begin
      req_seq(1'b1);
      unlock();
    end
    check("lock count", lock_count_out, 32'h100);
    req_seq(1'b1);
    check("lock limit", rf, 1'b1);
    check("still open", locked_out, 1'b0);
  endtask : t_lock
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    t_reset();
    t_modes();
    t_alert();
    t_outputs();
    t_misc();
    t_soft();
    t_lock();
    close_out();
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
endmodule : mode_and_output_select_config_bench
`default_nettype wire
